// [rtl/msc_pkg.sv]
// Constants shared by both ends of the mode and supply control link
// Summary of operation
// - Frame is 16 bits: address, access bit, data
// - Access bit 0 reads, register stays unchanged
// - Access bit 1 writes the data byte
// - Data bits D0..D7 ride frame bits 8..15
// - Reserved bits read 0, host writes 0
// - Control bits change by host writes and by soft reset, restart, overtemp and fo_hw_clear
// - Restart keeps unchanged bits, loads restart values
// - Mode and supply register resets to zero
// - Mode field: normal, sleep, stop, soft reset
// - Stop to sleep command is refused
// - Restart forces normal mode, secondary regulator off
// - Write returns previous register content
// - Bit 5 enables third regulator
// - Bits 4:3 select secondary regulator operation
// - Overvoltage flag always set, action gated
// - Bits 1:0 select reset threshold
// - Hardware bit 7 selects third regulator voltage
// - Hardware bit 6 suppresses reset pulse
// - Hardware bit 5 forces failure outputs
// - Hardware bit 4 keeps regulator at undervoltage
// - Bits 3 and 1 select load sharing
// - Bit 0 picks first or second watchdog failure
// - Soft reset keeps bits 7 and 3
package msc_pkg;
    localparam int          MSC_FRAME_W     = 16;
    localparam int          MSC_ADDR_W      = 7;
    localparam int          MSC_DATA_W      = 8;
    localparam int          MSC_ACC_BIT     = 7;
    localparam int          MSC_DATA_LSB    = 8;
    localparam logic [6:0]  MSC_ADDR_MS     = 7'h01;
    localparam logic [6:0]  MSC_ADDR_HW     = 7'h02;
    localparam logic [7:0]  MSC_MS_RESET    = 8'h00;
    localparam logic [7:0]  MSC_HW_RESET    = 8'h00;
    // Restart: ones mark bits that keep their value
    localparam logic [7:0]  MSC_MS_RST_KEEP = 8'h23;
    localparam logic [7:0]  MSC_HW_RST_KEEP = 8'hd9;
    localparam logic [7:0]  MSC_HW_SFT_KEEP = 8'h88;
    localparam logic [7:0]  MSC_HW_RSVD     = 8'h04;
    localparam logic [7:0]  MSC_HW_FO_BIT   = 8'h20;
    localparam logic [7:0]  MSC_MS_MODE_MSK = 8'hc0;
    localparam logic [7:0]  MSC_MS_SEC_MSK  = 8'h18;
    localparam logic [1:0]  MSC_MODE_NORMAL = 2'h0;
    localparam logic [1:0]  MSC_MODE_SLEEP  = 2'h1;
    localparam logic [1:0]  MSC_MODE_STOP   = 2'h2;
    localparam logic [1:0]  MSC_MODE_SOFT   = 2'h3;
    localparam int          MSC_DIV_DEF     = 4;
    localparam logic [31:0] MSC_APB_CMD     = 32'h00;
    localparam logic [31:0] MSC_APB_STAT    = 32'h04;
endpackage : msc_pkg

// [rtl/msc_link_if.sv]
// Serial link between host controller and register bank
`timescale 1ns/1ps
interface msc_link_if;
    logic sclk;
    logic csn;
    logic mosi;
    logic miso;
    modport host (output sclk, output csn, output mosi, input miso);
    modport dev  (input sclk, input csn, input mosi, output miso);
endinterface : msc_link_if

// [rtl/msc_host.sv]
// Host end: APB command registers driving serial frames
`timescale 1ns/1ps
module msc_host
    import msc_pkg::*;
#(
    parameter int DIV = MSC_DIV_DEF
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clk_en,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    msc_link_if.host         link
);
    typedef enum logic [1:0] {MSC_H_IDLE, MSC_H_LOW, MSC_H_HIGH, MSC_H_END} msc_hst_t;
    typedef struct packed {
        msc_hst_t    st;
        logic [15:0] sh;
        logic [15:0] rx;
        logic [4:0]  bits;
        logic [7:0]  div;
        logic        busy;
        logic        done;
        logic [1:0]  miso_s;
        logic [31:0] rdata;
        logic        sclk;
        logic        csn;
    } msc_hstate_t;
    msc_hstate_t s, next_s;
    logic wr_en;
    logic div_hit;
    assign wr_en   = psel && penable && pwrite;
    assign div_hit = s.div == 8'(DIV - 1);
    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign prdata  = s.rdata;
    assign link.sclk = s.sclk;
    assign link.csn  = s.csn;
    assign link.mosi = s.sh[0];
    always_comb begin
        next_s = s;
        next_s.miso_s = {s.miso_s[0], link.miso};
        next_s.div = div_hit ? 8'h00 : s.div + 8'h01;
        if (psel && !penable) begin
            next_s.rdata = (paddr == MSC_APB_STAT)
                ? {14'h0, s.done, s.busy, s.rx} : 32'h0;
        end
        case (s.st)
            MSC_H_IDLE: begin
                // Write launches one 16-bit frame, LSB first
                if (wr_en && paddr == MSC_APB_CMD && !s.busy) begin
                    next_s.sh   = pwdata[15:0];
                    next_s.bits = 5'h00;
                    next_s.busy = 1'b1;
                    next_s.done = 1'b0;
                    next_s.csn  = 1'b0;
                    next_s.div  = 8'h00;
                    next_s.st   = MSC_H_LOW;
                end
            end
            MSC_H_LOW: if (div_hit) begin
                next_s.sclk = 1'b1;
                next_s.st   = MSC_H_HIGH;
            end
            MSC_H_HIGH: if (div_hit) begin
                next_s.sclk = 1'b0;
                next_s.rx   = {s.miso_s[1], s.rx[15:1]};
                next_s.sh   = {1'b0, s.sh[15:1]};
                next_s.bits = s.bits + 5'h01;
                next_s.st   = (s.bits == 5'(MSC_FRAME_W - 1)) ? MSC_H_END : MSC_H_LOW;
            end
            MSC_H_END: if (div_hit) begin
                next_s.csn  = 1'b1;
                next_s.busy = 1'b0;
                next_s.done = 1'b1;
                next_s.st   = MSC_H_IDLE;
            end
            default: next_s.st = MSC_H_IDLE;
        endcase
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s      <= '0;
            s.csn  <= 1'b1;
            s.st   <= MSC_H_IDLE;
        end else if (clk_en) begin
            s <= next_s;
        end
    end
endmodule : msc_host

// [rtl/msc_dev.sv]
// Device end: mode and supply control register bank behind the serial link
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
module msc_dev
    import msc_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       clk_en,
    msc_link_if.dev         link,
    input  wire logic       restart_entry,
    input  wire logic       overtemp,
    input  wire logic       main_overvoltage,
    input  wire logic       fo_hw_clear,
    output logic            main_overvoltage_flag,
    output logic            overvoltage_action,
    output logic [1:0]      operating_mode,
    output logic            soft_reset_pulse,
    output logic            reset_output_n,
    output logic            third_regulator_enable,
    output logic [1:0]      secondary_regulator_control,
    output logic [1:0]      main_reset_threshold_select,
    output logic            third_regulator_voltage_select,
    output logic            failure_output_software_on,
    output logic            third_regulator_undervoltage_keep,
    output logic            third_regulator_load_share,
    output logic            load_share_in_stop_enable,
    output logic            first_wd_failure_select,
    output logic            link_miso
);
    typedef struct packed {
        logic [2:0]  sclk_s;
        logic [1:0]  csn_s;
        logic [1:0]  mosi_s;
        logic [15:0] rx;
        logic [15:0] tx;
        logic [4:0]  bits;
        logic [7:0]  ms;
        logic [7:0]  hw;
        logic        ov_flag;
        logic        soft_pulse;
        logic        ro_low;
        logic        miso;
    } msc_dstate_t;
    msc_dstate_t s, next_s;

    function automatic logic [7:0] msc_read(input logic [6:0] a, input logic [7:0] ms,
                                            input logic [7:0] hw);
        msc_read = (a == MSC_ADDR_MS) ? ms :
                   (a == MSC_ADDR_HW) ? (hw & ~MSC_HW_RSVD) : 8'h00;
    endfunction : msc_read

    logic sclk_rise;
    logic sclk_fall;
    logic csn_lo;
    logic [7:0] wdata;
    logic [6:0] addr;
    assign sclk_rise = s.sclk_s[1] && !s.sclk_s[2];
    assign sclk_fall = !s.sclk_s[1] && s.sclk_s[2];
    assign csn_lo    = !s.csn_s[1];
    assign addr      = s.rx[MSC_ADDR_W-1:0];
    assign wdata     = s.rx[MSC_DATA_LSB +: MSC_DATA_W];

    always_comb begin
        next_s = s;
        next_s.sclk_s = {s.sclk_s[1:0], link.sclk};
        next_s.csn_s  = {s.csn_s[0], link.csn};
        next_s.mosi_s = {s.mosi_s[0], link.mosi};
        next_s.soft_pulse = 1'b0;
        next_s.ro_low     = 1'b0;
        if (!csn_lo) begin
            next_s.bits = 5'h00;
            next_s.tx   = 16'h0;
            next_s.miso = 1'b0;
        end else if (sclk_rise) begin
            next_s.rx   = {s.mosi_s[1], s.rx[15:1]};
            next_s.bits = s.bits + 5'h01;
            if (s.bits == 5'(MSC_ADDR_W)) begin
                // Reply byte loads from old content before any update
                // Reply byte leaves from the low end, one bit per falling clock
                next_s.tx = {8'h00, msc_read(s.rx[15:9], s.ms, s.hw)};
            end
        end else if (sclk_fall) begin
            next_s.miso = s.tx[0];
            next_s.tx   = {1'b0, s.tx[15:1]};
            if (s.bits == 5'(MSC_FRAME_W) && s.rx[MSC_ACC_BIT]) begin
                if (addr == MSC_ADDR_MS) begin
                    if (!(s.ms[7:6] == MSC_MODE_STOP && wdata[7:6] == MSC_MODE_SLEEP))
                        next_s.ms = wdata;
                    else
                        next_s.ms = {s.ms[7:6], wdata[5:0]};
                end else if (addr == MSC_ADDR_HW) begin
                    next_s.hw = wdata & ~MSC_HW_RSVD;
                end
                next_s.bits = 5'h00;
            end
        end
        // Soft reset command self-clears after one cycle
        if (s.ms[7:6] == MSC_MODE_SOFT) begin
            next_s.ms = MSC_MS_RESET;
            next_s.hw = (s.hw & MSC_HW_SFT_KEEP) | (MSC_HW_RESET & ~MSC_HW_SFT_KEEP);
            next_s.soft_pulse = 1'b1;
            next_s.ro_low     = !s.hw[6];
        end
        if (main_overvoltage) next_s.ov_flag = 1'b1;
        if (overtemp) next_s.ms = next_s.ms & ~MSC_MS_SEC_MSK;
        if (restart_entry) begin
            next_s.ms = next_s.ms & MSC_MS_RST_KEEP;
            next_s.hw = next_s.hw & MSC_HW_RST_KEEP & ~MSC_HW_FO_BIT;
        end
        if (fo_hw_clear) next_s.hw = next_s.hw & ~MSC_HW_FO_BIT;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
            s.sclk_s <= 3'h0;
            s.csn_s  <= 2'h3;
            s.ms     <= MSC_MS_RESET;
            s.hw     <= MSC_HW_RESET;
        end else if (clk_en) begin
            s <= next_s;
        end
    end

    assign link.miso = s.miso;
    assign link_miso = s.miso;
    assign operating_mode                    = s.ms[7:6];
    assign third_regulator_enable            = s.ms[5];
    assign secondary_regulator_control       = s.ms[4:3];
    assign main_reset_threshold_select       = s.ms[1:0];
    assign main_overvoltage_flag             = s.ov_flag;
    assign overvoltage_action                = main_overvoltage && s.ms[2];
    assign soft_reset_pulse                  = s.soft_pulse;
    assign reset_output_n                    = !s.ro_low;
    assign third_regulator_voltage_select    = s.hw[7];
    assign failure_output_software_on        = s.hw[5];
    assign third_regulator_undervoltage_keep = s.hw[4];
    assign third_regulator_load_share        = s.hw[3];
    assign load_share_in_stop_enable         = s.hw[1];
    assign first_wd_failure_select           = s.hw[0];
endmodule : msc_dev

// [tb/msc_link_sva.sv]
// Timing and framing checks on the serial link between the two ends
`timescale 1ns/1ps
module msc_link_sva #(
    parameter int DIV = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic sclk,
    input wire logic csn,
    input wire logic mosi,
    input wire logic miso
);
    logic       sclk_q;
    logic [7:0] phase;
    logic [5:0] rises;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_q <= 1'b0;
            phase  <= 8'h00;
            rises  <= 6'h00;
        end else begin
            sclk_q <= sclk;
            phase  <= (sclk != sclk_q) ? 8'h01 : phase + 8'h01;
            rises  <= csn ? 6'h00 : rises + 6'(sclk & ~sclk_q);
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_idle; csn |-> !sclk; endproperty
    a_idle: assert property (p_idle) else $error("clock runs outside frame");
    property p_high; $fell(sclk) |-> phase == DIV; endproperty
    a_high: assert property (p_high) else $error("clock high phase length");
    property p_low; $rose(sclk) && rises != 6'h00 |-> phase == DIV; endproperty
    a_low: assert property (p_low) else $error("clock low phase length");
    property p_count; $rose(csn) |-> rises == 6'h10; endproperty
    a_count: assert property (p_count) else $error("frame is not 16 bits");
    property p_cap; $rose(sclk) |-> rises < 6'h10; endproperty
    a_cap: assert property (p_cap) else $error("more than 16 clock pulses");
    property p_mosi; sclk && sclk_q |-> $stable(mosi); endproperty
    a_mosi: assert property (p_mosi) else $error("host data moved in high phase");
    property p_miso; sclk && sclk_q |-> $stable(miso); endproperty
    a_miso: assert property (p_miso) else $error("reply data moved in high phase");
    property p_start; $fell(csn) |-> ##[1:40] $rose(sclk); endproperty
    a_start: assert property (p_start) else $error("frame did not start");
    property p_len; $fell(csn) |-> ##[120:200] $rose(csn); endproperty
    a_len: assert property (p_len) else $error("frame length out of range");
    c_frame: cover property ($rose(csn));
    c_mosi: cover property ($rose(sclk) && mosi);
    c_miso: cover property (sclk && miso);
endmodule : msc_link_sva

// [tb/mode_supply_control_regs_test.sv]
// Self-checking bench: host and device ends joined over the serial link
`timescale 1ns/1ps
module mode_supply_control_regs_test;
    import msc_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, saw_ro;
    logic        fo_hw_clear, soft_reset_pulse, saw_sp;
    logic        restart_entry, overtemp, main_overvoltage, main_overvoltage_flag;
    logic        overvoltage_action, reset_output_n, third_regulator_enable;
    logic        third_regulator_voltage_select, failure_output_software_on;
    logic        third_regulator_undervoltage_keep, third_regulator_load_share;
    logic        load_share_in_stop_enable, first_wd_failure_select;
    logic [1:0]  operating_mode, secondary_regulator_control, main_reset_threshold_select;
    logic [7:0]  ms, hw, lf, got;
    logic [31:0] paddr, pwdata, prdata, rd;
    int          n_mismatch, checks_done;
    msc_link_if link ();
    msc_host #(.DIV(MSC_DIV_DEF)) u_msc_host (.pclk, .presetn, .clk_en(1'b1), .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr(), .link(link.host));
    msc_dev u_msc_dev (.pclk, .presetn, .clk_en(1'b1), .link(link.dev), .restart_entry,
        .overtemp, .main_overvoltage, .fo_hw_clear, .main_overvoltage_flag,
        .overvoltage_action, .operating_mode, .soft_reset_pulse, .reset_output_n,
        .third_regulator_enable, .secondary_regulator_control, .main_reset_threshold_select,
        .third_regulator_voltage_select, .failure_output_software_on,
        .third_regulator_undervoltage_keep, .third_regulator_load_share,
        .load_share_in_stop_enable, .first_wd_failure_select, .link_miso());
    msc_link_sva #(.DIV(MSC_DIV_DEF)) u_msc_link_sva (.pclk, .presetn, .sclk(link.sclk),
        .csn(link.csn), .mosi(link.mosi), .miso(link.miso));
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    always @(posedge pclk) if (reset_output_n === 1'b0) saw_ro <= 1'b1;
    always @(posedge pclk) if (soft_reset_pulse === 1'b1) saw_sp <= 1'b1;
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr
    task automatic results();
        $display("Checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : results
    task automatic cmp(input logic [7:0] g, input logic [7:0] e);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %0t: got %h expected %h", $time, g, e);
        end
    endtask : cmp
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Request holds until pready is seen high at a rising edge
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        if (n >= 50) n_mismatch++;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic frame(input logic wr, input logic [6:0] a, input logic [7:0] d);
        int n;
        n = 0;
        apb(1'b1, MSC_APB_CMD, {16'h0000, d, wr, a});
        do begin
            apb(1'b0, MSC_APB_STAT, 32'h0);
            n++;
        end while ((rd[16] !== 1'b0 || rd[17] !== 1'b1) && n < 400);
        if (n >= 400) n_mismatch++;
        got = rd[15:8];
    endtask : frame
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] old;
        old = (a == MSC_ADDR_MS) ? ms : (a == MSC_ADDR_HW) ? hw : 8'h00;
        frame(1'b1, a, d);
        cmp(got, old);
        if (a == MSC_ADDR_HW) hw = d & ~MSC_HW_RSVD;
        if (a == MSC_ADDR_MS && !(ms[7:6] == MSC_MODE_STOP && d[7:6] == MSC_MODE_SLEEP)) ms = d;
        if (a == MSC_ADDR_MS && ms[7:6] == MSC_MODE_STOP && d[7:6] == MSC_MODE_SLEEP) ms[5:0] = d[5:0];
        if (a == MSC_ADDR_MS && d[7:6] == MSC_MODE_SOFT) begin
            ms = MSC_MS_RESET;
            hw = hw & MSC_HW_SFT_KEEP;
        end
        repeat (4) @(posedge pclk);
    endtask : wr
    task automatic chk_all();
        frame(1'b0, MSC_ADDR_MS, 8'h00);
        cmp(got, ms);
        frame(1'b0, MSC_ADDR_HW, 8'h00);
        cmp(got, hw);
        cmp({operating_mode, third_regulator_enable, secondary_regulator_control, 1'b0,
            main_reset_threshold_select}, ms & 8'hfb);
        cmp({third_regulator_voltage_select, 1'b0, failure_output_software_on,
            third_regulator_undervoltage_keep, third_regulator_load_share, 1'b0,
            load_share_in_stop_enable, first_wd_failure_select}, hw & 8'hbb);
    endtask : chk_all
    task automatic pulse(input logic [1:0] k);
        if (k == 2'h1) restart_entry <= 1'b1;
        else if (k == 2'h2) fo_hw_clear <= 1'b1;
        else overtemp <= 1'b1;
        @(posedge pclk);
        restart_entry <= 1'b0;
        overtemp      <= 1'b0;
        fo_hw_clear   <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask : pulse
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {restart_entry, overtemp, main_overvoltage, saw_ro, fo_hw_clear, saw_sp} = '0;
        n_mismatch = 0;
        checks_done = 0;
        ms = MSC_MS_RESET;
        hw = MSC_HW_RESET;
        lf = 8'h49;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk_all();
        $display("Reset values test done");
        for (int i = 0; i < 12; i++) begin
            lf = lfsr(lf);
            wr(MSC_ADDR_MS, lf);
            lf = lfsr(lf);
            wr(MSC_ADDR_HW, lf & ~MSC_HW_RSVD);
            chk_all();
        end
        $display("Random write test done");
        wr(MSC_ADDR_MS, 8'h80);
        wr(MSC_ADDR_MS, 8'h55);
        wr(7'h05, 8'hff);
        wr(7'h00, 8'hff);
        chk_all();
        $display("Refused write test done");
        for (int i = 0; i < 2; i++) begin
            wr(MSC_ADDR_HW, i ? 8'hfb : 8'hbb);
            saw_ro = 1'b0;
            saw_sp = 1'b0;
            wr(MSC_ADDR_MS, 8'hff);
            cmp({6'h00, saw_sp, saw_ro}, i ? 8'h02 : 8'h03);
            chk_all();
        end
        $display("Soft reset test done");
        wr(MSC_ADDR_MS, 8'hbf);
        wr(MSC_ADDR_HW, 8'hfb);
        pulse(2'h2);
        hw = hw & ~MSC_HW_FO_BIT;
        chk_all();
        wr(MSC_ADDR_HW, 8'hfb);
        pulse(2'h1);
        ms = ms & MSC_MS_RST_KEEP;
        hw = hw & MSC_HW_RST_KEEP;
        chk_all();
        wr(MSC_ADDR_MS, 8'h1c);
        pulse(2'h0);
        ms = ms & ~MSC_MS_SEC_MSK;
        chk_all();
        $display("Restart test done");
        main_overvoltage <= 1'b1;
        repeat (3) @(posedge pclk);
        cmp({6'h00, main_overvoltage_flag, overvoltage_action}, 8'h03);
        wr(MSC_ADDR_MS, 8'h00);
        cmp({6'h00, main_overvoltage_flag, overvoltage_action}, 8'h02);
        main_overvoltage <= 1'b0;
        $display("Overvoltage test done");
        results();
    end
    initial begin
        repeat (60000) @(posedge pclk);
        n_mismatch++;
        results();
    end
endmodule : mode_supply_control_regs_test
